// file: rtl/rsg_top.sv
// reset generation, clock selection and system clock division
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module rsg_top (
    input wire logic I_SYS_CLK,
    input wire logic I_RST,
    input wire logic I_POR_BOR,
    input wire logic I_SHUTDOWN_EXIT,
    input wire logic I_WDG_TIMEOUT,
    input wire logic I_CORE_LOCKUP,
    input wire logic I_DBG_CONNECTED,
    input wire logic I_DBG_RESET_REQ,
    input wire logic I_EXTERNAL_RESET_PIN_N,
    output logic O_EXTERNAL_RESET_PIN_OUT,
    output logic O_EXTERNAL_RESET_PIN_OE,
    output logic O_POWER_ON_RESET_N,
    output logic O_SYSTEM_RESET_N,
    input wire logic I_XTAL_READY,
    input wire logic I_PLL_LOCKED,
    input wire logic I_SLOW_RC_TICK,
    input wire logic I_SLOW_XTAL_TICK,
    input wire logic I_DEEPSTOP,
    output logic [1:0] O_ROOT_SEL,
    output logic [1:0] O_SLOW_SEL,
    output logic O_SLOW_TICK,
    output logic O_SYSCLK,
    output logic O_SYSCLK_EN,
    output logic O_CLK_ACCURATE,
    output logic O_RADIO_CLK_OK,
    input wire logic [3:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST
);
    logic por_src;
    logic por_active;
    logic lockup_eff;
    logic int_src;
    logic int_active;
    logic pad_ext_low;
    logic sys_active;
    logic sw_req;
    logic bus_req;
    logic ack;
    logic wr_en;
    logic accurate;
    logic rootdiv_tick;
    logic [31:0] rd_mux;
    logic [rsg_pkg::SLOW_DIV_W-1:0] slow_cnt;
    rsg_pkg::rsg_clk_cfg_type cfg;
    rsg_pkg::rsg_cause_type cause;
    rsg_pkg::rsg_cause_type cause_set;

    // ************************************************
    // reset sources
    // ************************************************
    assign por_src = I_POR_BOR | I_SHUTDOWN_EXIT; // RULE_01 RULE_02
    assign lockup_eff = I_CORE_LOCKUP & ~I_DBG_CONNECTED; // RULE_04
    assign int_src = I_WDG_TIMEOUT | lockup_eff | sw_req | I_DBG_RESET_REQ; // RULE_03
    // own drive would read back as low, so the pad only counts while released
    assign pad_ext_low = ~I_EXTERNAL_RESET_PIN_N & ~O_EXTERNAL_RESET_PIN_OE; // RULE_09
    assign sys_active = por_active | int_active | pad_ext_low; // RULE_03

    rsg_stretch #(
        .COUNT(rsg_pkg::STRETCH_CYC),
        .START_ACTIVE(1'b1)
    ) u_por_stretch (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_trig(por_src),
        .o_active(por_active)
    );

    rsg_stretch #(
        .COUNT(rsg_pkg::STRETCH_CYC),
        .START_ACTIVE(1'b0)
    ) u_int_stretch (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_trig(int_src),
        .o_active(int_active)
    );

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_POWER_ON_RESET_N <= 1'b0;
            O_SYSTEM_RESET_N <= 1'b0;
            O_EXTERNAL_RESET_PIN_OE <= 1'b1;
        end else begin
            O_POWER_ON_RESET_N <= ~por_active; // RULE_01
            O_SYSTEM_RESET_N <= ~sys_active; // RULE_03
            O_EXTERNAL_RESET_PIN_OE <= por_active | int_active; // RULE_06
        end
    end

    assign O_EXTERNAL_RESET_PIN_OUT = 1'b0; // RULE_06

    // ************************************************
    // register bus
    // ************************************************
    assign bus_req = I_AVS_READ | I_AVS_WRITE;
    assign O_AVS_WAITREQUEST = bus_req & ~ack;
    assign wr_en = I_AVS_WRITE & ack;

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_req & ~ack;
        end
    end

    always_comb begin
        rd_mux = '0;
        unique case (I_AVS_ADDRESS)
            rsg_pkg::OFS_CLK_CFG: begin
                rd_mux[rsg_pkg::CFG_DIV_LSB +: 3] = cfg.div_sel;
                rd_mux[rsg_pkg::CFG_ROOT_LSB +: 2] = cfg.root;
                rd_mux[rsg_pkg::CFG_SLOW_LSB +: 2] = cfg.slow;
            end
            rsg_pkg::OFS_RST_CTRL: begin
                rd_mux[rsg_pkg::RST_SWREQ_BIT] = sw_req;
            end
            rsg_pkg::OFS_STATUS: begin
                rd_mux[rsg_pkg::STA_CAUSE_LSB +: 5] = cause;
                rd_mux[rsg_pkg::STA_ACC_BIT] = O_CLK_ACCURATE;
                rd_mux[rsg_pkg::STA_RADIO_BIT] = O_RADIO_CLK_OK;
                rd_mux[rsg_pkg::STA_DBG_BIT] = I_DBG_CONNECTED;
            end
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_AVS_READDATA <= '0;
        end else if (bus_req && !ack) begin
            O_AVS_READDATA <= rd_mux;
        end
    end

    // ************************************************
    // reset control and cause registers
    // ************************************************
    // the request clears itself through the very reset it causes
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            sw_req <= 1'b0;
        end else if (sys_active) begin
            sw_req <= 1'b0;
        end else if (wr_en && I_AVS_ADDRESS == rsg_pkg::OFS_RST_CTRL
                     && I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[rsg_pkg::RST_SWREQ_BIT]) begin
            sw_req <= 1'b1; // RULE_05
        end
    end

    always_comb begin
        cause_set.por = por_src;
        cause_set.pad = pad_ext_low;
        cause_set.sw = sw_req | I_DBG_RESET_REQ;
        cause_set.lockup = lockup_eff;
        cause_set.wdg = I_WDG_TIMEOUT;
    end

    // cause flags survive system reset; write one clears, a new event wins
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            cause <= rsg_pkg::CAUSE_RST;
        end else if (wr_en && I_AVS_ADDRESS == rsg_pkg::OFS_STATUS && I_AVS_BYTEENABLE[0]) begin
            cause <= (cause & ~I_AVS_WRITEDATA[rsg_pkg::STA_CAUSE_LSB +: 5]) | cause_set;
        end else begin
            cause <= cause | cause_set;
        end
    end

    // ************************************************
    // clock configuration
    // ************************************************
    // source selects are kept across system reset, only power-on clears them
    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            cfg.root <= rsg_pkg::ROOT_FAST_RC;
            cfg.slow <= rsg_pkg::SLOW_RC;
        end else if (por_active) begin
            cfg.root <= rsg_pkg::ROOT_FAST_RC; // RULE_07
            cfg.slow <= rsg_pkg::SLOW_RC;
        end else if (wr_en && I_AVS_ADDRESS == rsg_pkg::OFS_CLK_CFG) begin
            if (I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[rsg_pkg::CFG_ROOT_LSB +: 2] != 2'h3) begin
                cfg.root <= rsg_pkg::rsg_root_type'(I_AVS_WRITEDATA[rsg_pkg::CFG_ROOT_LSB +: 2]);
            end
            if (I_AVS_BYTEENABLE[1] && I_AVS_WRITEDATA[rsg_pkg::CFG_SLOW_LSB +: 2] != 2'h3) begin
                cfg.slow <= rsg_pkg::rsg_slow_type'(I_AVS_WRITEDATA[rsg_pkg::CFG_SLOW_LSB +: 2]);
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            cfg.div_sel <= rsg_pkg::DIV_RST;
        end else if (sys_active) begin
            cfg.div_sel <= rsg_pkg::DIV_RST; // RULE_15 RULE_07
        end else if (wr_en && I_AVS_ADDRESS == rsg_pkg::OFS_CLK_CFG && I_AVS_BYTEENABLE[0]) begin
            cfg.div_sel <= I_AVS_WRITEDATA[rsg_pkg::CFG_DIV_LSB +: 3];
        end
    end

    rsg_clk_div #(
        .DIV_W(7)
    ) u_div (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_sel(cfg.div_sel),
        .i_xtal_direct(cfg.root == rsg_pkg::ROOT_XTAL),
        .o_clk(O_SYSCLK),
        .o_en(O_SYSCLK_EN)
    );

    // shared RC/PLL block is only trimmed once the crystal runs and PLL locks
    always_comb begin
        unique case (cfg.root)
            rsg_pkg::ROOT_XTAL: accurate = I_XTAL_READY;
            default: accurate = I_XTAL_READY & I_PLL_LOCKED; // RULE_14
        endcase
    end

    // root/512 has no Deepstop source, so it simply stops there
    assign rootdiv_tick = (slow_cnt == '1) & ~I_DEEPSTOP; // RULE_12

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            slow_cnt <= '0;
        end else if (!I_DEEPSTOP) begin
            slow_cnt <= slow_cnt + rsg_pkg::SLOW_DIV_W'(1); // RULE_11
        end
    end

    always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_SLOW_TICK <= 1'b0;
            O_CLK_ACCURATE <= 1'b0;
            O_RADIO_CLK_OK <= 1'b0;
            O_ROOT_SEL <= 2'h0;
            O_SLOW_SEL <= 2'h0;
        end else begin
            unique case (cfg.slow)
                rsg_pkg::SLOW_XTAL: O_SLOW_TICK <= I_SLOW_XTAL_TICK;
                rsg_pkg::SLOW_ROOTDIV: O_SLOW_TICK <= rootdiv_tick;
                default: O_SLOW_TICK <= I_SLOW_RC_TICK; // RULE_11
            endcase
            O_CLK_ACCURATE <= accurate;
            O_RADIO_CLK_OK <= accurate & (cfg.root != rsg_pkg::ROOT_FAST_RC); // RULE_13
            O_ROOT_SEL <= cfg.root; // RULE_10
            O_SLOW_SEL <= cfg.slow;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    por_assert_a: assert property (I_POR_BOR |=> !O_POWER_ON_RESET_N) // RULE_01
        else $error("power-on reset not asserted after brown-out");
    shutdown_exit_a: assert property ( // RULE_02
        I_SHUTDOWN_EXIT |=> (!O_POWER_ON_RESET_N && !O_SYSTEM_RESET_N))
        else $error("shutdown exit did not act as power-on");
    wdg_reset_a: assert property (I_WDG_TIMEOUT |=> !O_SYSTEM_RESET_N) // RULE_03
        else $error("watchdog timeout did not reset system");
    lockup_mask_a: assert property ( // RULE_04
        (I_CORE_LOCKUP && I_DBG_CONNECTED && !I_WDG_TIMEOUT && !sw_req
         && !I_DBG_RESET_REQ && !int_active) |=> !(int_active && !int_src))
        else $error("lockup reset not masked with debugger");
    sw_request_a: assert property ( // RULE_05
        (wr_en && I_AVS_ADDRESS == rsg_pkg::OFS_RST_CTRL && I_AVS_BYTEENABLE[0]
         && I_AVS_WRITEDATA[0] && !sys_active) |=> ##1 !O_SYSTEM_RESET_N)
        else $error("software reset request ignored");
    pad_drive_a: assert property ( // RULE_06
        (por_active || int_active) |=> (O_EXTERNAL_RESET_PIN_OE && !O_EXTERNAL_RESET_PIN_OUT))
        else $error("reset pin not driven low during reset");
    keep_root_a: assert property ( // RULE_07
        (sys_active && !por_active && !wr_en) |=> $stable(cfg.root))
        else $error("root select lost on system reset");
    pad_hold_a: assert property (pad_ext_low |=> !O_SYSTEM_RESET_N) // RULE_09
        else $error("pad low did not hold system reset");
    div_default_a: assert property ( // RULE_15
        sys_active |=> cfg.div_sel == rsg_pkg::DIV_RST)
        else $error("divider not back to divide by four");
    deepstop_slow_a: assert property ( // RULE_12
        (I_DEEPSTOP && cfg.slow == rsg_pkg::SLOW_ROOTDIV) |=> !O_SLOW_TICK)
        else $error("root/512 slow tick in Deepstop");
    accuracy_a: assert property (!I_XTAL_READY |=> !O_CLK_ACCURATE) // RULE_14
        else $error("clock flagged accurate without crystal");

    cover property ($fell(O_SYSTEM_RESET_N) && O_POWER_ON_RESET_N);
    cover property (pad_ext_low ##1 !pad_ext_low);
    cover property (wr_en && I_AVS_ADDRESS == rsg_pkg::OFS_CLK_CFG);
endmodule

// file: common/rsg_pkg.sv
// constants and types shared by the reset and system clock generator
// How it works
// [RULE_01] power-on or brown-out from the power unit asserts power_on_reset_n, clearing everything.
// [RULE_02] leaving Shutdown counts as power-on and asserts power_on_reset_n.
// [RULE_03] system_reset_n follows power-on, watchdog, lockup, software/debugger request, reset pin.
// [RULE_04] core lockup is ignored while a debugger is connected.
// [RULE_05] setting software_reset_request in core_reset_control_reg causes a system reset.
// [RULE_06] external_reset_pin_n is driven low while a system reset is generated.
// [RULE_07] system reset spares debug, keys, RTC, power unit and some clock registers.
// [RULE_08] every internal reset source is stretched to at least 20 us.
// [RULE_09] a reset from the pad lasts as long as the pad is held low.
// [RULE_10] root clock chosen from fast RC, crystal-locked PLL or crystal direct.
// [RULE_11] slow clock chosen from slow RC, slow crystal or root divided by 512.
// [RULE_12] software avoids the root/512 slow clock for Deepstop peripherals.
// [RULE_13] software picks PLL or crystal root before using the radio.
// [RULE_14] root clock is accurate only once crystal runs and PLL locks; with the crystal-direct root the code flags it accurate once the crystal runs.
// [RULE_15] after reset the root clock is divided by four; code 010 divides by three if a system reset keeps the crystal-direct root.
// [RULE_16] divider codes 000, 001, 010 give 1, 2, and 4 or 3 with crystal.
// [RULE_17] codes 011 to 110 give 8..64 or 6..48; not used with radio active.
// [RULE_18] software keeps system_clock at or above radio_clock.
// [RULE_19] divider changes only at a period boundary, never a short phase.
package rsg_pkg;
    // ************************************************
    // timing
    // ************************************************
    localparam int SYS_CLK_KHZ = 25000;
    localparam int STRETCH_NS = 20000;
    localparam int STRETCH_CYC = (STRETCH_NS * SYS_CLK_KHZ + 999999) / 1000000;
    localparam int SLOW_DIV = 512;
    localparam int SLOW_DIV_W = $clog2(SLOW_DIV);
    // ************************************************
    // register map
    // ************************************************
    localparam logic [3:0] OFS_CLK_CFG = 4'h0;
    localparam logic [3:0] OFS_RST_CTRL = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam int CFG_DIV_LSB = 0;
    localparam int CFG_ROOT_LSB = 4;
    localparam int CFG_SLOW_LSB = 8;
    localparam int RST_SWREQ_BIT = 0;
    localparam int STA_CAUSE_LSB = 0;
    localparam int STA_ACC_BIT = 8;
    localparam int STA_RADIO_BIT = 9;
    localparam int STA_DBG_BIT = 10;
    localparam logic [2:0] DIV_RST = 3'h2;
    localparam logic [6:0] DIV_RST_RATIO = 7'h04;
    localparam logic [4:0] CAUSE_RST = 5'h10;
    // ************************************************
    // types
    // ************************************************
    typedef enum logic [1:0] {
        ROOT_FAST_RC = 2'b00,
        ROOT_PLL = 2'b01,
        ROOT_XTAL = 2'b10
    } rsg_root_type;
    typedef enum logic [1:0] {
        SLOW_RC = 2'b00,
        SLOW_XTAL = 2'b01,
        SLOW_ROOTDIV = 2'b10
    } rsg_slow_type;
    typedef struct packed {
        logic por;
        logic pad;
        logic sw;
        logic lockup;
        logic wdg;
    } rsg_cause_type;
    typedef struct packed {
        logic [2:0] div_sel;
        rsg_root_type root;
        rsg_slow_type slow;
    } rsg_clk_cfg_type;
endpackage

// file: rtl/rsg_stretch.sv
// reset pulse stretcher with a minimum active length
`timescale 1ns/1ps
module rsg_stretch #(
    parameter int COUNT = rsg_pkg::STRETCH_CYC,
    parameter bit START_ACTIVE = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_trig,
    output logic o_active
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(COUNT);
    localparam logic [CW-1:0] CNT_INIT = START_ACTIVE ? CW'(COUNT) : '0;
    logic [CW-1:0] cnt;

    // reload on every trigger cycle so the tail always counts from release
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= CNT_INIT;
        end else if (i_trig) begin
            cnt <= CNT_LOAD; // RULE_08
        end else if (cnt != '0) begin
            cnt <= cnt - CW'(1);
        end
    end

    assign o_active = i_trig | (cnt != '0);

    // ************************************************
    // checks
    // ************************************************
    load_full_a: assert property ( // RULE_08
        @(posedge i_clk) disable iff (i_rst) i_trig |=> cnt == CNT_LOAD)
        else $error("stretch counter not loaded to full length");
    tail_step_a: assert property ( // RULE_08
        @(posedge i_clk) disable iff (i_rst)
        (cnt != '0 && !i_trig)
        |=> (cnt == $past(cnt) - CW'(1) && (o_active || $past(cnt) == CW'(1))))
        else $error("stretch tail shorter than programmed");
endmodule

// file: rtl/rsg_clk_div.sv
// system clock divider with boundary-aligned ratio change
`timescale 1ns/1ps
module rsg_clk_div #(
    parameter int DIV_W = 7
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [2:0] i_sel,
    input wire logic i_xtal_direct,
    output logic o_clk,
    output logic o_en
);
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic [DIV_W-1:0] next_div;
    logic wrap;

    function automatic logic [DIV_W-1:0] ratio(input logic [2:0] sel, input logic x);
        int r;
        unique case (sel)
            3'h0: r = 1;
            3'h1: r = 2;
            3'h2: r = x ? 3 : 4; // RULE_16
            3'h3: r = x ? 6 : 8; // RULE_17
            3'h4: r = x ? 12 : 16;
            3'h5: r = x ? 24 : 32;
            default: r = x ? 48 : 64;
        endcase
        return DIV_W'(r);
    endfunction

    assign wrap = (cnt == div - DIV_W'(1));

    // new ratio is only loaded at wrap, so no phase gets cut short
    always_comb begin
        next_cnt = wrap ? '0 : cnt + DIV_W'(1);
        next_div = wrap ? ratio(i_sel, i_xtal_direct) : div; // RULE_19
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= '0;
            div <= DIV_W'(rsg_pkg::DIV_RST_RATIO); // RULE_15
        end else begin
            cnt <= next_cnt;
            div <= next_div;
        end
    end

    // high for the first half (rounded up) of each period
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_clk <= 1'b1;
            o_en <= 1'b1;
        end else begin
            o_clk <= next_cnt < ((next_div + DIV_W'(1)) >> 1);
            o_en <= next_cnt == '0;
        end
    end

    // ************************************************
    // checks
    // ************************************************
    ratio_hold_a: assert property ( // RULE_19
        @(posedge i_clk) disable iff (i_rst) !wrap |=> $stable(div))
        else $error("divider ratio changed inside a period");
    ratio_three_a: assert property ( // RULE_16
        @(posedge i_clk) disable iff (i_rst)
        (wrap && i_sel == 3'h2 && i_xtal_direct) |=> div == DIV_W'(3))
        else $error("code 010 with crystal did not divide by 3");
    ratio_slow_a: assert property ( // RULE_17
        @(posedge i_clk) disable iff (i_rst)
        (wrap && i_sel == 3'h6 && !i_xtal_direct) |=> div == DIV_W'(64))
        else $error("code 110 without crystal did not divide by 64");
endmodule

// file: test/rsg_far_side.sv
// model of the reset pad, its pull-up and the slow oscillators
`timescale 1ns/1ps
module rsg_far_side (
    input wire logic i_clk,
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    input wire logic i_hold_low,
    output logic o_pad_n,
    output logic o_rc_tick,
    output logic o_xtal_tick
);
    int cnt = 0;
    // open drain with pull-up: low while either party pulls it
    assign o_pad_n = (i_pin_oe && !i_pin_out) ? 1'b0 : !i_hold_low;
    // slow ticks scaled down so a period fits a short run
    assign o_rc_tick = (cnt % 40) == 1;
    assign o_xtal_tick = (cnt % 24) == 7;
    always @(posedge i_clk) begin
        cnt <= cnt + 1;
    end
endmodule

// file: test/reset_and_sysclk_gen_test.sv
// self-checking bench for the reset and system clock generator
`timescale 1ns/1ps
module reset_and_sysclk_gen_test;
    logic clk, rst, dbg_con, hold_low, xtal_rdy, pll_lock, deepstop, rd, wr;
    logic [4:0] src;
    logic [3:0] addr;
    logic [31:0] wdata, q;
    logic pad_n, pin_out, pin_oe, por_n, sys_n, rc_tick, xt_tick, slow_tick;
    logic sysclk, sysclk_en, accurate, radio_ok, waitreq;
    logic [1:0] root_sel, slow_sel;
    logic [31:0] rdata;
    int bad_count = 0;
    int total_checks = 0;
    int n;
    int r0[7] = '{1, 2, 4, 8, 16, 32, 64};
    int r1[7] = '{1, 2, 3, 6, 12, 24, 48};
    rsg_top i_rsg_top (.I_SYS_CLK(clk), .I_RST(rst), .I_POR_BOR(src[4]),
        .I_SHUTDOWN_EXIT(src[3]), .I_WDG_TIMEOUT(src[0]), .I_CORE_LOCKUP(src[1]),
        .I_DBG_CONNECTED(dbg_con), .I_DBG_RESET_REQ(src[2]),
        .I_EXTERNAL_RESET_PIN_N(pad_n), .O_EXTERNAL_RESET_PIN_OUT(pin_out),
        .O_EXTERNAL_RESET_PIN_OE(pin_oe), .O_POWER_ON_RESET_N(por_n),
        .O_SYSTEM_RESET_N(sys_n), .I_XTAL_READY(xtal_rdy), .I_PLL_LOCKED(pll_lock),
        .I_SLOW_RC_TICK(rc_tick), .I_SLOW_XTAL_TICK(xt_tick), .I_DEEPSTOP(deepstop),
        .O_ROOT_SEL(root_sel), .O_SLOW_SEL(slow_sel), .O_SLOW_TICK(slow_tick),
        .O_SYSCLK(sysclk), .O_SYSCLK_EN(sysclk_en), .O_CLK_ACCURATE(accurate),
        .O_RADIO_CLK_OK(radio_ok), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
        .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(4'hF), .I_AVS_WRITEDATA(wdata),
        .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq));
    rsg_far_side i_rsg_far_side (.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
        .i_hold_low(hold_low), .o_pad_n(pad_n), .o_rc_tick(rc_tick),
        .o_xtal_tick(xt_tick));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic timeout(input string what);
        bad_count++;
        $display("CHECK FAILED %s expected end of wait seen timeout", what);
        finish_test();
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    // one transfer; the request holds until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            k++;
            if (k > 50) timeout("waitrequest");
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(name, e, q);
    endtask
    task automatic pulse(input int s);
        @(posedge clk);
        src[s] <= 1'b1;
        @(posedge clk);
        src <= 5'h00;
    endtask
    // length of one reset pulse; internal resets must drive the pin all along
    task automatic low_len(input bit p);
        int k;
        bit oe_ok;
        k = 0;
        n = 0;
        oe_ok = 1'b1;
        do begin
            cyc(1);
            k++;
            if (k > 10) timeout("reset start");
        end while ((p ? por_n : sys_n) !== 1'b0);
        while ((p ? por_n : sys_n) === 1'b0) begin
            if (pin_oe !== 1'b1) oe_ok = 1'b0;
            cyc(1);
            n++;
            if (n > 5000) timeout("reset end");
        end
        chk("pin driven", 1, oe_ok);
        chk("stretch", 1, n >= rsg_pkg::STRETCH_CYC && n <= rsg_pkg::STRETCH_CYC + 3);
    endtask
    // cycles between the second and third pulse, so a pending ratio has landed
    task automatic period(input bit s);
        int k;
        for (int i = 0; i < 3; i++) begin
            k = 0;
            do begin
                cyc(1);
                k++;
                if (k > 2000) timeout("period");
            end while ((s ? slow_tick : sysclk_en) !== 1'b1);
        end
        n = k;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst = 1'b1;
        src = 5'h00;
        {dbg_con, hold_low, xtal_rdy, pll_lock, deepstop, rd, wr} = 7'h00;
        addr = 4'h0;
        wdata = 32'h0000_0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        low_len(1'b1);
        chk("system reset off", 1, sys_n);
        rd_chk("config", rsg_pkg::OFS_CLK_CFG, 32'h0000_0002);
        period(1'b0);
        chk("reset ratio", 4, n);
        $display("test power-up done");
        for (int s = 0; s < 3; s++) begin
            pulse(s);
            low_len(1'b0);
            chk("power-on untouched", 1, por_n);
        end
        rd_chk("cause", rsg_pkg::OFS_STATUS, 32'h0000_0017);
        bus(1'b1, rsg_pkg::OFS_RST_CTRL, 32'h0000_0001);
        low_len(1'b0);
        @(posedge clk);
        dbg_con <= 1'b1;
        pulse(1);
        cyc(20);
        chk("lockup masked", 1, sys_n);
        @(posedge clk);
        dbg_con <= 1'b0;
        $display("test system sources done");
        bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'h0000_0020);
        pulse(0);
        low_len(1'b0);
        rd_chk("kept root", rsg_pkg::OFS_CLK_CFG, 32'h0000_0022);
        for (int s = 3; s < 5; s++) begin
            pulse(s);
            low_len(1'b1);
            cyc(2);
            chk("system reset off", 1, sys_n);
        end
        rd_chk("cleared", rsg_pkg::OFS_CLK_CFG, 32'h0000_0002);
        $display("test power-on sources done");
        @(posedge clk);
        hold_low <= 1'b1;
        cyc(700);
        chk("pad held", 0, sys_n);
        chk("pad not driven", 0, pin_oe);
        @(posedge clk);
        hold_low <= 1'b0;
        n = 0;
        while (sys_n !== 1'b1) begin
            cyc(1);
            n++;
            if (n > 5) timeout("pad release");
        end
        $display("test pad done");
        for (int rt = 0; rt < 2; rt++) begin
            for (int c = 0; c < 7; c++) begin
                bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'(c) | (32'(rt * 2) << 4));
                period(1'b0);
                chk("ratio", rt ? r1[c] : r0[c], n);
            end
        end
        chk("root crystal", 2'b10, root_sel);
        $display("test divider done");
        bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'h0000_0012);
        xtal_rdy <= 1'b1;
        cyc(3);
        chk("not locked", 0, accurate);
        chk("radio clock", 0, radio_ok);
        @(posedge clk);
        pll_lock <= 1'b1;
        cyc(3);
        chk("locked", 1, accurate);
        chk("radio clock", 1, radio_ok);
        chk("root pll", 2'b01, root_sel);
        bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'h0000_0002);
        cyc(3);
        chk("radio on rc", 0, radio_ok);
        $display("test accuracy done");
        bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'h0000_0102);
        period(1'b1);
        chk("slow crystal", 24, n);
        bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'h0000_0002);
        period(1'b1);
        chk("slow rc", 40, n);
        bus(1'b1, rsg_pkg::OFS_CLK_CFG, 32'h0000_0202);
        period(1'b1);
        chk("root div", rsg_pkg::SLOW_DIV, n);
        chk("slow select", 2'b10, slow_sel);
        @(posedge clk);
        deepstop <= 1'b1;
        cyc(2);
        n = 0;
        repeat (600) begin
            cyc(1);
            n = n + (slow_tick === 1'b1);
        end
        chk("stopped in deepstop", 0, n);
        @(posedge clk);
        deepstop <= 1'b0;
        bus(1'b1, 4'hC, 32'hFFFF_FFFF);
        rd_chk("unmapped", 4'hC, 32'h0000_0000);
        $display("test slow clock done");
        finish_test();
    end
endmodule
